// ### logic/irq_reroute_pkg.sv
// package: constants and types for the switch interrupt capture reroute
package irq_reroute_pkg;
    // ==========================================================
    // channel and event widths
    localparam int CHAN_COUNT = 8;
    localparam int EVENT_COUNT = 16;
    localparam int EVENT_SEL_W = 4;
    localparam int EVENT_SELECT_W = 12;
    localparam int COUNT_W = 32;

    // ==========================================================
    // capture event mux numbering and field positions
    localparam logic [3:0] EVENT_COMBINED_RX = 4'h8;
    localparam logic [3:0] EVENT_COMBINED_TX = 4'h9;
    localparam int SEL_A_LSB = 0;
    localparam int SEL_B_LSB = 8;
    localparam logic [11:0] EVENT_SELECT_RESET = 12'h908;

    // ==========================================================
    // host controller line numbers of the relay timers
    localparam int HOST_LINE_TIMER_A = 93;
    localparam int HOST_LINE_TIMER_B = 94;

    // ==========================================================
    // capture edge encodings
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ==========================================================
    // pacing timebase: 1 us at 25 MHz
    localparam int CLK_HZ = 25_000_000;
    localparam int PACE_TICK_NS = 1000;
    localparam int PACE_TICK_CYCLES = (PACE_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [4:0] PACE_TICK_LAST = 5'(PACE_TICK_CYCLES - 1);
    localparam logic [7:0] PACE_GAP_RESET = 8'h00;

    // ==========================================================
    // relay timer settings carried as one bundle
    typedef struct packed {
        logic capture_mode_select; // 0 single capture, 1 second edge
        logic [1:0] capture_edge_select;
        logic irq_enable_set;
    } relay_cfg_t;

    // pacing state per combined line
    typedef enum logic [1:0] {
        PACE_IDLE = 2'b00,
        PACE_ACTIVE = 2'b01,
        PACE_HOLDOFF = 2'b10
    } pace_state_t;
endpackage

// ### logic/relay_timer.sv
// relay timer in capture mode: edge detect, capture, sticky flag
`timescale 1ns/1ps
module relay_timer (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire irq_reroute_pkg::relay_cfg_t cfg,
    input wire logic event_in,
    input wire logic flag_clear,
    output logic relay_irq,
    output logic [31:0] capture_value
);
    logic [31:0] count_reg;
    logic event_last_reg;
    logic armed_reg;
    logic capture_irq_flag_reg;
    logic edge_hit;

    // ==========================================================
    // edge select
    always_comb begin
        case (cfg.capture_edge_select)
            irq_reroute_pkg::EDGE_RISE: edge_hit = event_in & ~event_last_reg;
            irq_reroute_pkg::EDGE_FALL: edge_hit = ~event_in & event_last_reg;
            irq_reroute_pkg::EDGE_BOTH: edge_hit = event_in ^ event_last_reg;
            default: edge_hit = 1'b0;
        endcase
    end

    // free counter; its value means nothing to the host
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            count_reg <= 32'h0;
            event_last_reg <= 1'b0;
        end else begin
            count_reg <= count_reg + 32'h1;
            event_last_reg <= event_in;
        end
    end

    // capture register, kept only for visibility
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            capture_value <= 32'h0;
        end else if (edge_hit) begin
            capture_value <= count_reg;
        end
    end

    // second-edge mode arms on the first edge, flags on the next
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            armed_reg <= 1'b0;
        end else if (edge_hit && cfg.capture_mode_select) begin
            armed_reg <= ~armed_reg;
        end else if (!cfg.capture_mode_select) begin
            armed_reg <= 1'b0;
        end
    end

    // sticky flag; a new edge beats a write-one clear
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            capture_irq_flag_reg <= 1'b0;
        end else if (edge_hit && (!cfg.capture_mode_select || armed_reg)) begin
            capture_irq_flag_reg <= 1'b1;
        end else if (flag_clear) begin
            capture_irq_flag_reg <= 1'b0;
        end
    end

    // interrupt to the host controller, registered
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            relay_irq <= 1'b0;
        end else begin
            relay_irq <= capture_irq_flag_reg & cfg.irq_enable_set;
        end
    end
endmodule

// ### logic/switch_irq_capture_reroute.sv
// top: combine switch channel interrupts and relay them via capture timers
`timescale 1ns/1ps
module switch_irq_capture_reroute (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] tx_channel_irq,
    input wire logic [7:0] rx_channel_irq,
    input wire logic pace_enable,
    input wire logic [7:0] pace_gap,
    input wire logic [11:0] capture_event_select,
    input wire irq_reroute_pkg::relay_cfg_t relay_timer_a_cfg,
    input wire irq_reroute_pkg::relay_cfg_t relay_timer_b_cfg,
    input wire logic relay_timer_a_flag_clear,
    input wire logic relay_timer_b_flag_clear,
    output logic [7:0] tx_channel_out,
    output logic [7:0] rx_channel_out,
    output logic combined_tx_irq,
    output logic combined_rx_irq,
    output logic relay_timer_a_irq,
    output logic relay_timer_b_irq,
    output logic [31:0] relay_timer_a_capture,
    output logic [31:0] relay_timer_b_capture
);
    logic [4:0] tick_cnt_reg;
    logic tick;
    irq_reroute_pkg::pace_state_t tx_state_reg;
    irq_reroute_pkg::pace_state_t rx_state_reg;
    logic [7:0] tx_gap_reg;
    logic [7:0] rx_gap_reg;
    logic tx_any;
    logic rx_any;
    logic [15:0] event_bus;
    logic event_a;
    logic event_b;

    // next pacing state for one combined line
    function automatic irq_reroute_pkg::pace_state_t pace_next(
        input irq_reroute_pkg::pace_state_t st,
        input logic any,
        input logic en,
        input logic [7:0] gap
    );
        case (st)
            irq_reroute_pkg::PACE_IDLE: pace_next = any ? irq_reroute_pkg::PACE_ACTIVE : st;
            irq_reroute_pkg::PACE_ACTIVE: begin
                if (any) begin
                    pace_next = st;
                end else if (en && gap != 8'h00) begin
                    pace_next = irq_reroute_pkg::PACE_HOLDOFF;
                end else begin
                    pace_next = irq_reroute_pkg::PACE_IDLE;
                end
            end
            irq_reroute_pkg::PACE_HOLDOFF: pace_next = st;
            default: pace_next = irq_reroute_pkg::PACE_IDLE;
        endcase
    endfunction

    // hold-off ends on the tick that takes the count from one to zero
    function automatic logic holdoff_done(
        input logic tk,
        input logic [7:0] gap
    );
        holdoff_done = tk && (gap == 8'h01);
    endfunction

    // a combined line shows only while its pacing state is active
    function automatic logic line_active(
        input irq_reroute_pkg::pace_state_t st
    );
        line_active = (st == irq_reroute_pkg::PACE_ACTIVE);
    endfunction

    // one selection field of the event mux; a 4-bit field cannot leave the bus
    function automatic logic pick_event(
        input logic [15:0] events,
        input logic [3:0] field
    );
        pick_event = events[field];
    endfunction

    // ==========================================================
    // channel merge
    assign tx_any = |tx_channel_irq;
    assign rx_any = |rx_channel_irq;

    // tx channels pass straight through; pacing here would delay per-channel service
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_channel_out <= 8'h00;
        end else begin
            tx_channel_out <= tx_channel_irq;
        end
    end

    // rx channels pass straight through, unpaced
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rx_channel_out <= 8'h00;
        end else begin
            rx_channel_out <= rx_channel_irq;
        end
    end

    // ==========================================================
    // 1 us pacing timebase
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tick_cnt_reg <= 5'h00;
        end else if (tick) begin
            tick_cnt_reg <= 5'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 5'h01;
        end
    end
    assign tick = (tick_cnt_reg == irq_reroute_pkg::PACE_TICK_LAST);

    // tx pacing state: after a drop, hold off for pace_gap ticks of the free 1 us timebase
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_state_reg <= irq_reroute_pkg::PACE_IDLE;
        end else if (tx_state_reg != irq_reroute_pkg::PACE_HOLDOFF) begin
            tx_state_reg <= pace_next(tx_state_reg, tx_any, pace_enable, pace_gap);
        end else if (holdoff_done(tick, tx_gap_reg)) begin
            tx_state_reg <= irq_reroute_pkg::PACE_IDLE;
        end
    end

    // tx hold-off count, reloaded whenever the line is not holding off
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_gap_reg <= irq_reroute_pkg::PACE_GAP_RESET;
        end else if (tx_state_reg != irq_reroute_pkg::PACE_HOLDOFF) begin
            tx_gap_reg <= pace_gap;
        end else if (tick) begin
            tx_gap_reg <= tx_gap_reg - 8'h01;
        end
    end

    // rx pacing state, same scheme; free tick means the gap may run one tick short
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rx_state_reg <= irq_reroute_pkg::PACE_IDLE;
        end else if (rx_state_reg != irq_reroute_pkg::PACE_HOLDOFF) begin
            rx_state_reg <= pace_next(rx_state_reg, rx_any, pace_enable, pace_gap);
        end else if (holdoff_done(tick, rx_gap_reg)) begin
            rx_state_reg <= irq_reroute_pkg::PACE_IDLE;
        end
    end

    // rx hold-off count
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rx_gap_reg <= irq_reroute_pkg::PACE_GAP_RESET;
        end else if (rx_state_reg != irq_reroute_pkg::PACE_HOLDOFF) begin
            rx_gap_reg <= pace_gap;
        end else if (tick) begin
            rx_gap_reg <= rx_gap_reg - 8'h01;
        end
    end

    // combined tx follows its paced state, one cycle late
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            combined_tx_irq <= 1'b0;
        end else begin
            combined_tx_irq <= line_active(tx_state_reg);
        end
    end

    // combined rx follows its paced state, one cycle late
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            combined_rx_irq <= 1'b0;
        end else begin
            combined_rx_irq <= line_active(rx_state_reg);
        end
    end

    // ==========================================================
    // capture event mux; unused events stay low
    always_comb begin
        event_bus = 16'h0000;
        event_bus[irq_reroute_pkg::EVENT_COMBINED_RX] = combined_rx_irq;
        event_bus[irq_reroute_pkg::EVENT_COMBINED_TX] = combined_tx_irq;
    end
    // selection fields come from software, 0x908 in normal use
    assign event_a = pick_event(event_bus, capture_event_select[irq_reroute_pkg::SEL_A_LSB +: 4]);
    assign event_b = pick_event(event_bus, capture_event_select[irq_reroute_pkg::SEL_B_LSB +: 4]);

    // timer a relays rx toward host line 93
    relay_timer u_relay_timer_a (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .cfg(relay_timer_a_cfg),
        .event_in(event_a),
        .flag_clear(relay_timer_a_flag_clear),
        .relay_irq(relay_timer_a_irq),
        .capture_value(relay_timer_a_capture)
    );

    // timer b relays tx toward host line 94
    relay_timer u_relay_timer_b (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .cfg(relay_timer_b_cfg),
        .event_in(event_b),
        .flag_clear(relay_timer_b_flag_clear),
        .relay_irq(relay_timer_b_irq),
        .capture_value(relay_timer_b_capture)
    );
endmodule

// ### tb/irq_reroute_monitor.sv
// checker: timing of combined and relayed interrupts at the block ports
`timescale 1ns/1ps
module irq_reroute_monitor (
    input logic clk_sys,
    input logic rstn,
    input logic [7:0] tx_channel_irq,
    input logic [7:0] rx_channel_irq,
    input logic pace_enable,
    input irq_reroute_pkg::relay_cfg_t relay_timer_a_cfg,
    input irq_reroute_pkg::relay_cfg_t relay_timer_b_cfg,
    input logic relay_timer_a_flag_clear,
    input logic [7:0] tx_channel_out,
    input logic combined_tx_irq,
    input logic combined_rx_irq,
    input logic relay_timer_a_irq,
    input logic relay_timer_b_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ========
    // combining: with pacing off, any channel raises its line two edges on; none keeps the tx line low
    property p_tx_or;
        tx_channel_irq != 8'h00 && !pace_enable |-> ##2 combined_tx_irq;
    endproperty
    a_tx_or: assert property (p_tx_or) else $error("tx combine late");
    property p_rx_or;
        rx_channel_irq != 8'h00 && !pace_enable |-> ##2 combined_rx_irq;
    endproperty
    a_rx_or: assert property (p_rx_or) else $error("rx combine late");
    property p_tx_hold;
        combined_tx_irq |-> $past(tx_channel_irq, 2) != 8'h00;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx line stale");
    property p_unpaced;
        tx_channel_out == $past(tx_channel_irq);
    endproperty
    a_unpaced: assert property (p_unpaced) else $error("channel delayed");
    // ========
    // relaying: a rise reaches the host line two edges later
    property p_rx_relay;
        $rose(combined_rx_irq) && relay_timer_a_cfg == 4'h3 |-> ##2 relay_timer_a_irq;
    endproperty
    a_rx_relay: assert property (p_rx_relay) else $error("rx relay lost");
    property p_tx_relay;
        $rose(combined_tx_irq) && relay_timer_b_cfg == 4'h3 ##1 relay_timer_b_cfg.irq_enable_set |=> relay_timer_b_irq;
    endproperty
    a_tx_relay: assert property (p_tx_relay) else $error("tx relay lost");
    property p_clear_a;
        relay_timer_a_flag_clear && !$rose(combined_rx_irq) |-> ##2 !relay_timer_a_irq;
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("flag not cleared");
    property p_mask_b;
        !relay_timer_b_cfg.irq_enable_set |=> !relay_timer_b_irq;
    endproperty
    a_mask_b: assert property (p_mask_b) else $error("masked irq seen");
    c_relay: cover property ($rose(relay_timer_a_irq));
    c_clear: cover property (relay_timer_a_flag_clear);
    c_mask: cover property (!relay_timer_b_cfg.irq_enable_set && combined_tx_irq);
    c_pace: cover property (pace_enable && $fell(combined_tx_irq));
endmodule
bind switch_irq_capture_reroute irq_reroute_monitor u_mon (.clk_sys, .rstn, .tx_channel_irq, .rx_channel_irq,
    .pace_enable, .relay_timer_a_cfg, .relay_timer_b_cfg, .relay_timer_a_flag_clear, .tx_channel_out,
    .combined_tx_irq, .combined_rx_irq, .relay_timer_a_irq, .relay_timer_b_irq);

// ### tb/irq_host_model.sv
// partner: host software that sets up the relay timers and services them
`timescale 1ns/1ps
module irq_host_model (
    input logic clk_sys,
    input logic irq_a,
    input logic irq_b,
    input logic mask_b,
    output logic [11:0] sel,
    output irq_reroute_pkg::relay_cfg_t cfg_a,
    output irq_reroute_pkg::relay_cfg_t cfg_b,
    output logic clr_a = 1'b0,
    output logic clr_b = 1'b0
);
    int wait_a = 0;
    int wait_b = 0;
    // ========
    // setup: rx to timer a, tx to timer b; single capture, rising edge, irq on except timer b while mask_b is high
    assign sel = 12'h908;
    assign cfg_a = 4'h3;
    assign cfg_b = {3'h1, !mask_b};
    // service: write-one clear, then back off three cycles before clearing again
    always @(negedge clk_sys) begin
        clr_a <= irq_a === 1'b1 && wait_a == 0;
        clr_b <= irq_b === 1'b1 && wait_b == 0;
        wait_a <= (irq_a === 1'b1 && wait_a == 0) ? 3 : (wait_a == 0 ? 0 : wait_a - 1);
        wait_b <= (irq_b === 1'b1 && wait_b == 0) ? 3 : (wait_b == 0 ? 0 : wait_b - 1);
    end
endmodule

// ### tb/switch_irq_capture_reroute_tb.sv
// testbench: reroute block against a cycle model, host software as partner
`timescale 1ns/1ps
module switch_irq_capture_reroute_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic mask_b = 1'b0;
    logic [11:0] sel;
    irq_reroute_pkg::relay_cfg_t cfg_a, cfg_b;
    logic clr_a, clr_b, irq_a, irq_b, ctx, crx;
    logic [7:0] otx, orx;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    logic pen = 1'b0;
    logic [7:0] pgap = 8'h00;
    logic [31:0] cap_a, cap_b;
    int e_ot, e_or, e_ct, e_cr, e_ct2, e_cr2;
    int e_fa, e_fb, e_ia, e_ib, e_ca, e_cb, e_cnt, tc, tk;
    int st[2];
    int gp[2];
    // ========
    // clock: 25 MHz
    initial forever #20 clk_sys = ~clk_sys;
    switch_irq_capture_reroute DUT (.clk_sys(clk_sys), .rstn(rstn), .tx_channel_irq(tx), .rx_channel_irq(rx),
        .pace_enable(pen), .pace_gap(pgap), .capture_event_select(sel), .relay_timer_a_cfg(cfg_a),
        .relay_timer_b_cfg(cfg_b), .relay_timer_a_flag_clear(clr_a), .relay_timer_b_flag_clear(clr_b),
        .tx_channel_out(otx), .rx_channel_out(orx), .combined_tx_irq(ctx), .combined_rx_irq(crx),
        .relay_timer_a_irq(irq_a), .relay_timer_b_irq(irq_b), .relay_timer_a_capture(cap_a),
        .relay_timer_b_capture(cap_b));
    irq_host_model u_host (.clk_sys(clk_sys), .irq_a(irq_a), .irq_b(irq_b), .mask_b(mask_b), .sel(sel),
        .cfg_a(cfg_a), .cfg_b(cfg_b), .clr_a(clr_a), .clr_b(clr_b));
    task automatic chk(input logic [31:0] got, input int exp);
        compares++;
        if (got !== 32'(exp)) begin
            num_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, 32'(exp));
        end
    endtask
    task automatic close_out();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ========
    // cycle model: pacing per line from a free 1 us tick, capture on a rise, set beats clear
    always @(posedge clk_sys) begin
        if (!rstn) begin
            e_ot = 0;
            e_or = 0;
            e_ct = 0;
            e_cr = 0;
            e_ct2 = 0;
            e_cr2 = 0;
            e_fa = 0;
            e_fb = 0;
            e_ia = 0;
            e_ib = 0;
            e_ca = 0;
            e_cb = 0;
            e_cnt = 0;
            tc = 0;
            st = '{0, 0};
            gp = '{0, 0};
        end else begin
            tk = (tc == irq_reroute_pkg::PACE_TICK_CYCLES - 1);
            tc = tk ? 0 : tc + 1;
            e_ia = e_fa && cfg_a.irq_enable_set;
            e_ib = e_fb && cfg_b.irq_enable_set;
            if (e_cr && !e_cr2) begin
                e_ca = e_cnt;
            end
            if (e_ct && !e_ct2) begin
                e_cb = e_cnt;
            end
            e_fa = (e_cr && !e_cr2) || (e_fa && !clr_a);
            e_fb = (e_ct && !e_ct2) || (e_fb && !clr_b);
            e_cnt++;
            e_ct2 = e_ct;
            e_cr2 = e_cr;
            e_ct = (st[0] == 1);
            e_cr = (st[1] == 1);
            e_ot = int'(tx);
            e_or = int'(rx);
            // states: 0 idle, 1 active, 2 holding off after a drop
            for (int k = 0; k < 2; k++) begin
                if (st[k] == 2) begin
                    if (tk && gp[k] == 1) begin
                        st[k] = 0;
                    end
                    if (tk) begin
                        gp[k]--;
                    end
                end else begin
                    if (st[k] == 0) begin
                        st[k] = int'((k ? rx : tx) != 8'h00);
                    end else if ((k ? rx : tx) == 8'h00) begin
                        st[k] = (pen && pgap != 8'h00) ? 2 : 0;
                    end
                    gp[k] = int'(pgap);
                end
            end
            #1;
            chk({24'h0, otx}, e_ot);
            chk({24'h0, orx}, e_or);
            chk({31'h0, ctx}, e_ct);
            chk({31'h0, crx}, e_cr);
            chk({31'h0, irq_a}, e_ia);
            chk({31'h0, irq_b}, e_ib);
            chk(cap_a, e_ca);
            chk(cap_b, e_cb);
        end
    end
    // hang guard: well above the few thousand cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            close_out();
        end
    end
    // stimulus: walking channels, then random bursts with a masked stretch and a reset
    initial begin
        void'($urandom(63204));
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            tx = 8'h01 << i;
            rx = 8'h80 >> i;
            repeat (8) @(negedge clk_sys);
            tx = 8'h00;
            rx = 8'h00;
            repeat (8) @(negedge clk_sys);
        end
        for (int n = 0; n < 300; n++) begin
            mask_b = n >= 100 && n < 150;
            tx = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
            rx = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
            if (n == 200) begin
                tx = 8'h00;
                rx = 8'h00;
                rstn = 1'b0;
            end
            repeat (1 + $urandom % 6) @(negedge clk_sys);
            rstn = 1'b1;
        end
        // pacing stretch: bursts of 1 to 60 cycles against a gap of one to three ticks
        pgap = 8'(1 + $urandom % 3);
        pen = 1'b1;
        for (int n = 0; n < 40; n++) begin
            tx = ($urandom % 2 == 0) ? 8'h00 : 8'($urandom);
            rx = ($urandom % 2 == 0) ? 8'h00 : 8'($urandom);
            repeat (1 + $urandom % 60) @(negedge clk_sys);
        end
        tx = 8'h00;
        rx = 8'h00;
        // let any hold-off run out before pacing goes off again
        repeat (150) @(negedge clk_sys);
        pen = 1'b0;
        repeat (4) @(negedge clk_sys);
        close_out();
    end
endmodule
